// ---- logic/eehc_pkg.sv ----
// Shared constants and types of the two-wire memory host controller.
// Assumes a 25 MHz system clock and a single target on an open-drain bus.
package eehc_pkg;

  // Clock and serial bit timing, each time in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  // A quarter of the serial clock is a least time, so it rounds up.
  localparam int unsigned Q_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned Q_W = 8;

  // Memory organisation of the target.
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGE_COUNT = 256;
  localparam int unsigned PAGE_OFS_W = 6;
  localparam int unsigned CNT_W = 7;

  // Device address byte layout and strap values.
  localparam int unsigned TYPE_W = 4;
  localparam int unsigned STRAP_W = 3;
  localparam logic [STRAP_W-1:0] BALL_STRAP = 3'h1;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [1:0] AHI_PAD = 2'h0;

  // Clocks given during bus recovery before giving up.
  localparam logic [3:0] RECOVER_MAX = 4'h9;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [2:0] {
    EEHC_IDLE, EEHC_START, EEHC_BYTE, EEHC_WAIT, EEHC_STOP, EEHC_RECOV
  } eehc_state_t;

  typedef enum logic [1:0] {
    OP_WRITE, OP_READ, OP_POLL, OP_RECOVER
  } eehc_op_t;

  typedef enum logic [2:0] {
    STG_DEV, STG_AHI, STG_ALO, STG_DATA, STG_RD
  } eehc_stage_t;

  typedef enum logic [1:0] {
    ERR_NONE, ERR_NACK, ERR_LEN, ERR_STUCK
  } eehc_err_t;

  typedef struct packed {
    eehc_op_t op;
    logic [STRAP_W-1:0] strap;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] count;
    logic keep_bus;
  } eehc_req_t;

  typedef struct packed {
    eehc_err_t err;
    eehc_stage_t stage;
    logic [7:0] rd_data;
  } eehc_resp_t;

endpackage

// ---- logic/eehc_host.sv ----
// Bus master for a two-wire serial memory: writes, polls, reads, recovery.
// Assumes the serial clock is made here and the data line has a pull-up;
// the command and write data ports come from logic on the same clock.
//
// How it works
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Master may end with repeated Start instead.
// - Transmitter releases data for ninth-clock acknowledge.
// - Master no-acknowledges to end device sending.
// - Acknowledger releases data after ninth clock.
// - Recovery clocks up to nine, then Start; this host sends a Stop instead.
// - Address byte: type, three straps, direction.
// - Ball package straps fixed at 0,0,1.
// - Two word address bytes follow address byte.
// - Write: Start, address, word bytes, data.
// - Stop after data launches busy write cycle.
// - Up to 63 more bytes, Stop commits.
// - Do not overrun the page end.
// - Sample on clock rise, change after fall.
// - Bytes go MSB first, no idle clocks.
`timescale 1ns/1ps

module eehc_host
  import eehc_pkg::*;
#(
  parameter logic [Q_W-1:0] QUARTER = Q_CYC[Q_W-1:0],
  parameter logic [TYPE_W-1:0] DEV_TYPE = 4'h5, // Arbitrary value.
  parameter bit BALL_PKG = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire eehc_req_t req,
  output logic req_ready,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic done,
  output eehc_resp_t resp,
  output logic scl_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  typedef struct packed {
    eehc_state_t state;
    eehc_stage_t stage;
    logic [Q_W-1:0] q;
    logic [1:0] ph;
    logic [3:0] bit_n;
    logic [7:0] sh;
    logic rxbit;
    logic [3:0] rcnt;
    eehc_req_t cmd;
    logic sda_s1;
    logic sda_s2;
    logic scl;
    logic sda_oe;
    logic sda_out;
    logic req_ready;
    logic wr_ready;
    logic done;
    eehc_resp_t resp;
  } eehc_st_t;

  // Reload one short, since the zero count is itself a counted cycle.
  localparam logic [Q_W-1:0] Q_LOAD = QUARTER - 8'h01;

  eehc_st_t s;
  eehc_st_t next_s;

  // Builds the device address byte; the ball package ignores the straps.
  function automatic logic [7:0] eehc_dev_byte(
    input logic [STRAP_W-1:0] strap,
    input logic rw
  );
    logic [STRAP_W-1:0] eff;
    eff = BALL_PKG ? BALL_STRAP : strap;
    return {DEV_TYPE, eff, rw};
  endfunction

  always_comb begin
    eehc_req_t c;
    logic [CNT_W-1:0] rem;
    logic tick;
    logic ack;
    logic fail;
    logic fin;
    c = s.cmd;
    rem = CNT_W'(PAGE_BYTES) - {1'b0, req.addr[PAGE_OFS_W-1:0]};
    tick = (s.q == '0);
    ack = ~s.rxbit;
    fail = 1'b0;
    fin = 1'b0;
    next_s = s;
    // The data line is a pin, so two flip-flops stand before any use.
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.done = 1'b0;
    next_s.sda_out = 1'b0;
    if (s.state != EEHC_IDLE && s.state != EEHC_WAIT) begin
      next_s.q = tick ? Q_LOAD : s.q - 8'h01;
      if (tick) begin
        next_s.ph = s.ph + 2'h1;
      end
    end
    unique case (s.state)
      EEHC_IDLE: begin
        next_s.req_ready = 1'b1;
        if (req_valid && s.req_ready) begin
          next_s.cmd = req;
          next_s.resp.err = ERR_NONE;
          next_s.resp.stage = STG_DEV;
          next_s.q = Q_LOAD;
          next_s.ph = 2'h0;
          next_s.bit_n = 4'h0;
          next_s.stage = STG_DEV;
          if (req.op == OP_RECOVER) begin
            next_s.req_ready = 1'b0;
            next_s.state = EEHC_RECOV;
            next_s.rcnt = 4'h0;
            next_s.scl = 1'b0;
            next_s.sda_oe = 1'b0;
          end else if (req.op == OP_WRITE &&
                       (req.count == '0 || req.count > rem)) begin
            // A write must fit in what is left of its page.
            next_s.done = 1'b1;
            next_s.resp.err = ERR_LEN;
          end else begin
            next_s.req_ready = 1'b0;
            next_s.state = EEHC_START;
            next_s.sh = eehc_dev_byte(req.strap,
              (req.op == OP_READ) ? RW_READ : RW_WRITE);
            // Clock drops first so that a held bus restarts cleanly.
            next_s.scl = 1'b0;
            next_s.sda_oe = 1'b0;
          end
        end
      end
      EEHC_START: begin
        // Clock rises over a released line, then data falls under it.
        if (tick) begin
          unique case (s.ph)
            2'h0: next_s.scl = 1'b1;
            2'h1: next_s.sda_oe = 1'b1;
            2'h2: next_s.sda_oe = 1'b1;
            2'h3: begin
              next_s.scl = 1'b0;
              next_s.state = EEHC_BYTE;
              next_s.bit_n = 4'h0;
            end
          endcase
        end
      end
      EEHC_BYTE: begin
        if (tick) begin
          unique case (s.ph)
            2'h0: begin
              // Data changes a quarter after the falling edge.
              // The ack slot and read bits leave the line free.
              next_s.sda_oe = (s.stage != STG_RD) &&
                              (s.bit_n != ACK_SLOT) && ~s.sh[7];
            end
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.rxbit = s.sda_s2;
            2'h3: begin
              next_s.scl = 1'b0;
              if (s.bit_n != ACK_SLOT) begin
                next_s.bit_n = s.bit_n + 4'h1;
                next_s.sh = {s.sh[6:0], s.rxbit};
              end else begin
                // Line stays released after the ninth clock.
                next_s.bit_n = 4'h0;
                next_s.sda_oe = 1'b0;
                next_s.resp.stage = s.stage;
                unique case (s.stage)
                  STG_DEV: begin
                    if (!ack) begin
                      fail = 1'b1;
                    end else if (c.op == OP_POLL) begin
                      fin = 1'b1;
                    end else if (c.op == OP_READ) begin
                      next_s.stage = STG_RD;
                    end else begin
                      next_s.stage = STG_AHI;
                      next_s.sh = {AHI_PAD, c.addr[13:8]};
                    end
                  end
                  STG_AHI: begin
                    if (!ack) begin
                      fail = 1'b1;
                    end else begin
                      next_s.stage = STG_ALO;
                      next_s.sh = c.addr[7:0];
                    end
                  end
                  STG_ALO: begin
                    if (!ack) begin
                      fail = 1'b1;
                    end else begin
                      next_s.stage = STG_DATA;
                      next_s.state = EEHC_WAIT;
                    end
                  end
                  STG_DATA: begin
                    if (!ack) begin
                      fail = 1'b1;
                    end else if (c.count == 7'h01) begin
                      fin = 1'b1;
                    end else begin
                      // The device advances within the page only.
                      next_s.cmd.count = c.count - 7'h01;
                      next_s.state = EEHC_WAIT;
                    end
                  end
                  STG_RD: begin
                    next_s.resp.rd_data = s.sh;
                    fin = 1'b1;
                  end
                  default: fail = 1'b1;
                endcase
              end
            end
          endcase
        end
      end
      EEHC_WAIT: begin
        // The clock is held low between bytes while data is awaited.
        // A slow source only stretches the low phase, which is allowed.
        next_s.wr_ready = 1'b1;
        if (s.wr_ready && wr_valid) begin
          next_s.wr_ready = 1'b0;
          next_s.sh = wr_data;
          next_s.state = EEHC_BYTE;
          next_s.bit_n = 4'h0;
          next_s.ph = 2'h0;
          next_s.q = Q_LOAD;
        end
      end
      EEHC_STOP: begin
        if (tick) begin
          unique case (s.ph)
            2'h0: next_s.sda_oe = 1'b1;
            2'h1: next_s.scl = 1'b1;
            // After a write this Stop starts the busy cycle.
            2'h2: next_s.sda_oe = 1'b0;
            2'h3: begin
              next_s.state = EEHC_IDLE;
              next_s.req_ready = 1'b1;
              next_s.done = 1'b1;
            end
          endcase
        end
      end
      EEHC_RECOV: begin
        // The line is left to the target while recovery clocks run.
        if (tick) begin
          unique case (s.ph)
            2'h0: next_s.sda_oe = 1'b0;
            2'h1: next_s.scl = 1'b1;
            2'h2: next_s.rxbit = s.sda_s2;
            2'h3: begin
              if (s.rxbit) begin
                // Line is free; a Stop leaves the bus idle.
                next_s.scl = 1'b0;
                next_s.state = EEHC_STOP;
              end else if (s.rcnt + 4'h1 == RECOVER_MAX) begin
                // Still held low after nine clocks: only power can help.
                next_s.resp.err = ERR_STUCK;
                next_s.state = EEHC_IDLE;
                next_s.req_ready = 1'b1;
                next_s.done = 1'b1;
              end else begin
                next_s.scl = 1'b0;
                next_s.rcnt = s.rcnt + 4'h1;
              end
            end
          endcase
        end
      end
      // An illegal state code falls back to a released, idle bus.
      default: begin
        next_s.state = EEHC_IDLE;
        next_s.scl = 1'b1;
        next_s.sda_oe = 1'b0;
      end
    endcase
    if (fail) begin
      next_s.resp.err = ERR_NACK;
      next_s.state = EEHC_STOP;
    end else if (fin) begin
      if (c.keep_bus) begin
        // Bus stays claimed for a repeated Start.
        next_s.state = EEHC_IDLE;
        next_s.req_ready = 1'b1;
        next_s.done = 1'b1;
      end else begin
        next_s.state = EEHC_STOP;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Clock and data start at their idle high levels, so the first
      // synchronised sample cannot look like a falling edge.
      s <= '{
        state: EEHC_IDLE,
        stage: STG_DEV,
        cmd: '0,
        resp: '{err: ERR_NONE, stage: STG_DEV, rd_data: 8'h00},
        scl: 1'b1,
        sda_s1: 1'b1,
        sda_s2: 1'b1,
        rxbit: 1'b1,
        default: '0
      };
    end else begin
      s <= next_s;
    end
  end

  assign req_ready = s.req_ready;
  assign wr_ready = s.wr_ready;
  assign done = s.done;
  assign resp = s.resp;
  assign scl_out = s.scl;
  assign sda_out = s.sda_out;
  assign sda_oe = s.sda_oe;

endmodule

// ---- sim/eehc_host_sva.sv ----
// Port checks on the two-wire memory host.
// Assumes the bench sets a short quarter count.
`timescale 1ns/1ps
module eehc_host_sva
  import eehc_pkg::*;
#(parameter logic [Q_W-1:0] QUARTER = Q_CYC[Q_W-1:0]) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire eehc_req_t req,
  input wire logic req_ready,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic done,
  input wire eehc_resp_t resp,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sda_low_a: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data driven high");
  idle_free_a: assert property (req_ready && scl_out |-> !sda_oe)
    else $error("idle bus held");
  edge_apart_a: assert property ($changed(sda_oe) |-> $stable(scl_out))
    else $error("data moved on clock edge");
  poll_time_a: assert property (s_take ##0 (req.op == OP_POLL)
    |=> !req_ready ##[20:400] done) else $error("poll length");
  len_refuse_a: assert property (s_take ##0 (req.op == OP_WRITE)
    ##0 (req.count == 7'h00) |=> ##[0:1] (done && resp.err == ERR_LEN))
    else $error("count zero taken");
  wr_take_a: assert property (wr_valid && wr_ready |=> !wr_ready)
    else $error("byte not taken");
  recover_end_a: assert property (s_take ##0 (req.op == OP_RECOVER)
    |-> ##[1:300] done) else $error("recovery too long");
  nack_stop_a: assert property (done && resp.err == ERR_NACK
    |-> scl_out && !sda_oe) else $error("no stop after refusal");
endmodule

bind eehc_host eehc_host_sva #(.QUARTER(QUARTER)) eehc_host_sva_i (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .done(done), .resp(resp), .scl_out(scl_out), .sda_out(sda_out),
  .sda_oe(sda_oe));

// ---- sim/eehc_dev_model.sv ----
// Behavioural serial memory target facing the host.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module eehc_dev_model
  import eehc_pkg::*;
#(
  parameter logic [TYPE_W-1:0] DEV_TYPE = 4'h5, // Arbitrary value.
  parameter int BUSY_NS = 30000
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [STRAP_W-1:0] strap,
  output logic sda_oe
);
  logic [7:0] mem [int];
  logic [7:0] sh, ob;
  logic [ADDR_W-1:0] ptr = '0;
  logic act = 1'b0, busy = 1'b0, dirty = 1'b0;
  int bitn = 0, stg = 0;
  // A floating strap reads low, as the target's pull-down makes it.
  wire [STRAP_W-1:0] strap_v = {strap[2] === 1'b1, strap[1] === 1'b1,
    strap[0] === 1'b1};
  initial sda_oe = 1'b0;
  // Blank cells read as all ones, so a stray read is never unknown.
  function automatic logic [7:0] rd_byte();
    return mem.exists(int'(ptr)) ? mem[int'(ptr)] : 8'hff;
  endfunction
  always @(negedge sda) if (scl && !busy) begin
    act = 1'b1;
    {bitn, stg} = '0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    if (dirty) begin
      {dirty, busy} = 2'b01;
      busy <= #BUSY_NS 1'b0;
    end
  end
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (stg == 4 && sda) act = 1'b0;
    bitn++;
  end
  always @(negedge scl) if (act) begin
    if (bitn == 8) begin
      sda_oe = (stg != 4);
      if (stg == 4) ptr = ptr + 1'b1;
      if (stg == 3) begin
        mem[int'(ptr)] = sh;
        ptr[5:0] = ptr[5:0] + 6'h01;
        dirty = 1'b1;
      end
      if (stg == 2) begin
        ptr[7:0] = sh;
        stg = 3;
      end
      if (stg == 1) begin
        ptr[13:8] = sh[5:0];
        stg = 2;
      end
      if (stg == 0) begin
        if (sh[7:1] != {DEV_TYPE, strap_v}) {act, sda_oe} = 2'b00;
        else stg = sh[0] ? 4 : 1;
      end
    end else begin
      if (bitn == 9) begin
        bitn = 0;
        ob = rd_byte();
      end
      sda_oe = (stg == 4) && !ob[7 - bitn];
    end
  end
endmodule

// ---- sim/eehc_host_test.sv ----
// Self-checking bench for the two-wire memory host.
// Assumes the target model and checker are compiled first.
`timescale 1ns/1ps
module eehc_host_test
  import eehc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  eehc_req_t req = '0;
  eehc_resp_t resp;
  logic req_ready, wr_ready, done, scl, sda_out, host_oe, dev_oe;
  logic stuck = 1'b0, keep = 1'b0;
  logic [2:0] strap = 3'h6;
  wire sda = (host_oe || dev_oe || stuck) ? 1'b0 : 1'b1;
  int failures = 0, cmp_count = 0, cyc = 0;
  eehc_host #(.QUARTER(8'h02), .DEV_TYPE(4'h5), .BALL_PKG(1'b0)) eehc_host_i (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .done(done), .resp(resp), .scl_out(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(host_oe));
  eehc_dev_model #(.DEV_TYPE(4'h5), .BUSY_NS(30000)) eehc_dev_model_i (
    .scl(scl), .sda(sda), .strap(strap), .sda_oe(dev_oe));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Feeds bytes 40h upward whenever the host asks, until done.
  task automatic run(input eehc_op_t op, input logic [2:0] s,
      input logic [13:0] a, input logic [6:0] n, output eehc_resp_t r);
    int k;
    logic tk;
    k = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req = '{op, s, a, n, keep};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (done !== 1'b1) begin
      wr_valid = wr_ready;
      wr_data = 8'h40 + 8'(k);
      tk = wr_valid && wr_ready;
      @(posedge clk);
      #1;
      k += int'(tk);
    end
    r = resp;
    wr_valid = 1'b0;
  endtask
  task automatic t_strap();
    eehc_resp_t r;
    run(OP_WRITE, 3'h3, 14'h0010, 7'h01, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NACK, STG_DEV});
    // An open strap pin reads low at the target.
    strap = 3'b0z1;
    run(OP_POLL, 3'h1, 14'h0000, 7'h00, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NONE, STG_DEV});
    strap = 3'h6;
  endtask
  task automatic t_length();
    eehc_resp_t r;
    run(OP_WRITE, 3'h6, 14'h0010, 7'h00, r);
    chk({6'h0, r.err}, {6'h0, ERR_LEN});
    run(OP_WRITE, 3'h6, 14'h007f, 7'h02, r);
    chk({6'h0, r.err}, {6'h0, ERR_LEN});
  endtask
  task automatic t_page();
    eehc_resp_t r;
    run(OP_WRITE, 3'h6, 14'h0040, 7'h40, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NONE, STG_DATA});
    run(OP_POLL, 3'h6, 14'h0000, 7'h00, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NACK, STG_DEV});
    for (int i = 0; i < 40 && r.err !== ERR_NONE; i++) begin
      run(OP_POLL, 3'h6, 14'h0000, 7'h00, r);
    end
    chk({6'h0, r.err}, {6'h0, ERR_NONE});
    // A full page wraps the pointer back onto its first byte.
    run(OP_READ, 3'h6, 14'h0000, 7'h00, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NONE, STG_RD});
    chk(r.rd_data, 8'h40);
    // A held bus lets the next read open with a repeated Start.
    keep = 1'b1;
    run(OP_POLL, 3'h6, 14'h0000, 7'h00, r);
    chk({3'h0, r.err, r.stage}, {3'h0, ERR_NONE, STG_DEV});
    chk({7'h0, scl}, 8'h00);
    keep = 1'b0;
    run(OP_READ, 3'h6, 14'h0000, 7'h00, r);
    chk(r.rd_data, 8'h41);
  endtask
  task automatic t_recover();
    eehc_resp_t r;
    run(OP_RECOVER, 3'h6, 14'h0000, 7'h00, r);
    chk({6'h0, r.err}, {6'h0, ERR_NONE});
    stuck = 1'b1;
    run(OP_RECOVER, 3'h6, 14'h0000, 7'h00, r);
    chk({6'h0, r.err}, {6'h0, ERR_STUCK});
    stuck = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_strap();
    t_length();
    t_page();
    t_recover();
    summarize();
  end
endmodule
